/* pkg/circ_if.sv */
// interface joining the processor end and peripheral ends
// assumes one peripheral per wire-or line: each resolved line copies its enable, no pull-up
`timescale 1ns/1ps
interface circ_if;
  logic irq_oe_n;  // peripheral pulls maskable line low when low
  logic nmi_oe_n;  // peripheral pulls non-maskable line low when low
  logic irq_n;     // resolved maskable line
  logic nmi_n;     // resolved non-maskable line
  logic rst_n;     // system reset line, active low
  logic ack_irq;   // maskable latch clear; circ_cpu always holds it low
  logic ack_nmi;
  assign irq_n = irq_oe_n;
  assign nmi_n = nmi_oe_n;
  modport cpu (input irq_n, input nmi_n, input rst_n,
    output ack_irq, output ack_nmi);
  modport per (output irq_oe_n, output nmi_oe_n, input rst_n,
    input ack_irq, input ack_nmi, input irq_n);
endinterface

/* pkg/circ_pkg.sv */
// package for the interrupt and reset acceptance block
// shared by the processor end and the bench; the peripheral interface end does not use it
package circ_pkg;
  // ----------------------------------------
  // widths and vector locations
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [15:0] RESET_VEC = 16'hfffc; // vector locations, low byte
  localparam logic [15:0] NMI_VEC = 16'hfffa;
  localparam logic [15:0] IRQ_VEC = 16'hfffe;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] SP_RST = 8'hfd;
  localparam logic [7:0] STATUS_RST = 8'h24;
  localparam int MASK_BIT = 2;       // mask flag position in status
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_NMI = 2'h1;
  localparam logic [1:0] SRC_IRQ = 2'h2;
  localparam logic [1:0] SRC_RST = 2'h3;

  // ----------------------------------------
  // service sequence states
  // ----------------------------------------
  typedef enum logic [2:0] {
    CIRC_RUN = 3'b000,
    CIRC_PUSH_HI = 3'b001,
    CIRC_PUSH_LO = 3'b010,
    CIRC_PUSH_ST = 3'b011,
    CIRC_VEC_LO = 3'b100,
    CIRC_VEC_HI = 3'b101
  } circ_state_t;
endpackage

/* verif/circ_monitor.sv */
// checker for the non-maskable processor/peripheral link
// assumes one peripheral drives the non-maskable line
`timescale 1ns/1ps
module circ_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic irq_oe_n,
  input wire logic nmi_oe_n,
  input wire logic irq_n,
  input wire logic nmi_n,
  input wire logic rst_n,
  input wire logic ack_irq,
  input wire logic ack_nmi
);
  // ------
  // helper
  // ------
  logic prev_q;
  logic pend_q;
  // a fall arms one acceptance, the ack spends it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b1;
      pend_q <= 1'b0;
    end else begin
      prev_q <= nmi_n;
      if (prev_q && !nmi_n) begin
        pend_q <= 1'b1;
      end else if (ack_nmi) begin
        pend_q <= 1'b0;
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ------
  // checks
  // ------
  a_nmi_from_edge: assert property (ack_nmi |-> pend_q)
    else $error("nmi ack without edge");
  a_nmi_held_quiet: assert property (ack_nmi |=> !ack_nmi [*8])
    else $error("nmi retaken");
  a_nmi_after_low: assert property (ack_nmi |-> !$past(nmi_n, 2))
    else $error("nmi ack too early");
  a_irq_ack_idle: assert property (!ack_irq)
    else $error("irq latch cleared by cpu");
  a_irq_released: assert property (irq_oe_n)
    else $error("irq line pulled");
  a_ack_releases: assert property (ack_nmi |=> nmi_oe_n)
    else $error("nmi line held after ack");
  a_reset_releases: assert property ($past(rst) |-> nmi_oe_n)
    else $error("line low after reset");
  a_reset_no_ack: assert property ($past(rst) |-> !ack_nmi [*3])
    else $error("ack during reset fetch");
  c_nmi_taken: cover property (ack_nmi);
  c_line_fall: cover property ($fell(nmi_n));
  c_line_rise: cover property ($rose(nmi_n));
endmodule

/* verif/tb_cpu_interrupt_reset_control.sv */
// bench: pair a carries non-maskable, pair b maskable requests
// assumes each end runs on core_clk with rst active high
`timescale 1ns/1ps
module tb_cpu_interrupt_reset_control;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic insn_done = 1'b0;
  logic clr_mask = 1'b0;
  logic rti_done = 1'b0;
  logic set_mask = 1'b0;
  logic int_en = 1'b1;
  logic dev_in = 1'b1;
  logic en_wr = 1'b0;
  logic clr = 1'b0;
  logic [7:0] rd_a, rd_b, wd_a;
  logic mask_a, mask_b, ld_a, flag_a, flag_b;
  logic [1:0] src_a;
  logic [15:0] ad_a, ad_b, pc_a, pc_b;
  logic busy_a, busy_b;
  int n_errors = 0;
  int checks = 0;
  // {edge, clear mask, return, busy a, busy b}
  logic [4:0] rows [6] = '{5'h12, 5'h00, 5'h09, 5'h05, 5'h00, 5'h12};
  circ_if lnk_a ();
  circ_if lnk_b ();
  assign lnk_a.rst_n = !rst;
  assign lnk_b.rst_n = !rst;
  circ_cpu i_circ_cpu (.core_clk, .rst, .lnk(lnk_a), .insn_done,
    .clr_mask, .set_mask, .rti_done, .status_in(8'h24),
    .rd_data(rd_a), .pc_in(16'h0400), .pc(pc_a), .sp(),
    .mask_flag(mask_a), .svc_busy(busy_a), .svc_src(src_a), .bus_wr(),
    .bus_rd(), .bus_addr(ad_a), .bus_wdata(wd_a), .pc_load(ld_a));
  circ_cpu i_circ_cpu_b (.core_clk, .rst, .lnk(lnk_b), .insn_done,
    .clr_mask, .set_mask, .rti_done, .status_in(8'h24),
    .rd_data(rd_b), .pc_in(16'h0400), .pc(pc_b), .sp(),
    .mask_flag(mask_b), .svc_busy(busy_b), .svc_src(), .bus_wr(),
    .bus_rd(), .bus_addr(ad_b), .bus_wdata(), .pc_load());
  circ_per #(.USE_NMI(1'b1)) i_circ_per (.core_clk, .rst, .lnk(lnk_a),
    .dev_in, .int_en, .en_wr, .clr, .flag(flag_a));
  circ_per i_circ_per_b (.core_clk, .rst, .lnk(lnk_b), .dev_in,
    .int_en, .en_wr, .clr, .flag(flag_b));
  circ_monitor i_circ_monitor (.core_clk, .rst,
    .irq_oe_n(lnk_a.irq_oe_n), .nmi_oe_n(lnk_a.nmi_oe_n),
    .irq_n(lnk_a.irq_n), .nmi_n(lnk_a.nmi_n), .rst_n(lnk_a.rst_n),
    .ack_irq(lnk_a.ack_irq), .ack_nmi(lnk_a.ack_nmi));
  // read bytes echo the address at once: data stands while rd is high
  assign rd_a = ad_a[7:0];
  assign rd_b = ad_b[7:0];
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic do_reset;
    rst = 1'b1;
    dev_in = 1'b1; // idle level, so no false edge after release
    cyc(5);
    rst = 1'b0;
    cyc(12);
    check("pc_a", pc_a, 16'hfdfc);
    check("pc_b", pc_b, 16'hfdfc);
    check("irq_oe_n", lnk_b.irq_oe_n, 1'b1);
    $display("reset test done");
  endtask
  // one boundary; an edge row first clears the latches and toggles
  task automatic run_row(input logic [4:0] r);
    if (r[4]) begin
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      dev_in = ~dev_in;
      cyc(8);
      check("busy_a idle", busy_a, 1'b0);
    end
    insn_done = 1'b1;
    clr_mask = r[3];
    rti_done = r[2];
    cyc(1);
    insn_done = 1'b0;
    clr_mask = 1'b0;
    rti_done = 1'b0;
    check("busy_a", busy_a, r[1]);
    check("busy_b", busy_b, r[0]);
    cyc(10);
  endtask
  // watchdog: the whole run needs well under 1000 cycles
  initial begin
    #50000;
    n_errors++;
    close_out;
  end
  initial begin
    do_reset;
    en_wr = 1'b1;
    cyc(1);
    en_wr = 1'b0;
    foreach (rows[i]) run_row(rows[i]);
    $display("row tests done");
    // mask by instruction: clear it, then set it again
    clr_mask = 1'b1;
    cyc(1);
    clr_mask = 1'b0;
    check("mask_b clear", mask_b, 1'b0);
    set_mask = 1'b1;
    cyc(1);
    set_mask = 1'b0;
    check("mask_a set", mask_a, 1'b1);
    // second device edge while the line is low is lost
    dev_in = ~dev_in;
    cyc(8);
    check("flag_a", flag_a, 1'b1);
    check("nmi_n a", lnk_a.nmi_n, 1'b0);
    dev_in = ~dev_in;
    cyc(8);
    insn_done = 1'b1;
    cyc(1);
    insn_done = 1'b0;
    check("src_a", src_a, circ_pkg::SRC_NMI);
    check("busy_b masked", busy_b, 1'b0);
    cyc(1);
    check("push addr", ad_a, 16'h01f7);
    check("push pc hi", wd_a, 8'h04);
    check("flag_a ack", flag_a, 1'b0);
    cyc(2);
    check("push status", wd_a, 8'h24);
    cyc(3);
    check("pc_load", ld_a, 1'b1);
    check("pc_a", pc_a, 16'hfbfa);
    run_row(5'h09);
    check("mask_b", mask_b, 1'b1);
    check("pc_b", pc_b, 16'hfffe);
    // local enable off releases a latched request
    int_en = 1'b0;
    en_wr = 1'b1;
    cyc(1);
    en_wr = 1'b0;
    check("irq_oe_n off", lnk_b.irq_oe_n, 1'b1);
    $display("edge test done");
    do_reset;
    close_out;
  end
endmodule

/* verilog/circ_cpu.sv */
// processor end: interrupt and reset acceptance
// assumes the core reports instruction end, flag-clear and return
`timescale 1ns/1ps
module circ_cpu #(
  parameter logic [15:0] RST_VEC = circ_pkg::RESET_VEC,
  parameter logic [15:0] NMI_V = circ_pkg::NMI_VEC,
  parameter logic [15:0] IRQ_V = circ_pkg::IRQ_VEC
) (
  input wire logic core_clk,
  input wire logic rst,
  circ_if.cpu lnk,
  input wire logic insn_done,
  input wire logic clr_mask,
  input wire logic set_mask,
  input wire logic rti_done,
  input wire logic [7:0] status_in,
  input wire logic [7:0] rd_data,
  input wire logic [15:0] pc_in,
  output logic [15:0] pc,
  output logic [7:0] sp,
  output logic mask_flag,
  output logic svc_busy,
  output logic [1:0] svc_src,
  output logic bus_wr,
  output logic bus_rd,
  output logic [15:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic pc_load
);
  typedef struct packed {
    circ_pkg::circ_state_t st;
    logic [15:0] pc;
    logic [7:0] sp;
    logic mask;
    logic nmi_prev;
    logic nmi_pend;
    logic [1:0] src;
    logic [15:0] vec;
    logic [7:0] stat;
    logic ack_irq;
    logic ack_nmi;
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic load;
  } circ_cpu_t;
  circ_cpu_t r_q, r_d;
  logic irq_s, nmi_s;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  circ_sync u_irq (
    .core_clk(core_clk),
    .rst(rst),
    .d(lnk.irq_n),
    .q(irq_s)
  );
  circ_sync u_nmi (
    .core_clk(core_clk),
    .rst(rst),
    .d(lnk.nmi_n),
    .q(nmi_s)
  );

  // ----------------------------------------
  // acceptance and service sequence
  // ----------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.ack_irq = 1'b0;
    r_d.ack_nmi = 1'b0;
    r_d.wr = 1'b0;
    r_d.rd = 1'b0;
    r_d.load = 1'b0;
    r_d.nmi_prev = nmi_s;
    // edge latched even mid-instruction; held low sets nothing
    if (r_q.nmi_prev && !nmi_s) begin
      r_d.nmi_pend = 1'b1;
    end
    unique case (r_q.st)
      circ_pkg::CIRC_RUN: begin
        if (clr_mask || rti_done) begin
          r_d.mask = 1'b0;
        end else if (set_mask) begin
          r_d.mask = 1'b1;
        end
        // return clears mask in the same check, so a low line retakes
        if (insn_done) begin
          if (r_q.nmi_pend) begin
            r_d.src = circ_pkg::SRC_NMI;
            r_d.vec = NMI_V;
            r_d.nmi_pend = r_q.nmi_prev && !nmi_s; // same-cycle edge kept
            r_d.ack_nmi = 1'b1;
          end else if (!irq_s && !(r_q.mask && !clr_mask && !rti_done))
          begin
            r_d.src = circ_pkg::SRC_IRQ;
            r_d.vec = IRQ_V;
          end
          if (r_d.src != circ_pkg::SRC_NONE) begin
            r_d.pc = pc_in;
            r_d.stat = status_in;
            r_d.mask = 1'b1;
            r_d.st = circ_pkg::CIRC_PUSH_HI;
          end
        end
      end
      circ_pkg::CIRC_PUSH_HI: begin
        r_d.wr = 1'b1;
        r_d.addr = {8'h01, r_q.sp};
        r_d.wdata = r_q.pc[15:8];
        r_d.sp = r_q.sp - 8'h01;
        r_d.st = circ_pkg::CIRC_PUSH_LO;
      end
      circ_pkg::CIRC_PUSH_LO: begin
        r_d.wr = 1'b1;
        r_d.addr = {8'h01, r_q.sp};
        r_d.wdata = r_q.pc[7:0];
        r_d.sp = r_q.sp - 8'h01;
        r_d.st = circ_pkg::CIRC_PUSH_ST;
      end
      circ_pkg::CIRC_PUSH_ST: begin
        r_d.wr = 1'b1;
        r_d.addr = {8'h01, r_q.sp};
        r_d.wdata = r_q.stat;
        r_d.sp = r_q.sp - 8'h01;
        r_d.st = circ_pkg::CIRC_VEC_LO;
      end
      circ_pkg::CIRC_VEC_LO: begin // rd_data sampled in the cycle rd is high
        r_d.rd = 1'b1;
        r_d.addr = r_q.vec;
        r_d.st = circ_pkg::CIRC_VEC_HI;
      end
      circ_pkg::CIRC_VEC_HI: begin
        // first read still on the bus, else the high byte has arrived
        if (r_q.addr == r_q.vec) begin
          r_d.pc[7:0] = rd_data;
          r_d.rd = 1'b1;
          r_d.addr = r_q.vec + 16'h0001;
        end else begin
          r_d.pc[15:8] = rd_data;
          r_d.load = 1'b1;
          r_d.src = circ_pkg::SRC_NONE;
          r_d.st = circ_pkg::CIRC_RUN;
        end
      end
      default: r_d.st = circ_pkg::CIRC_RUN;
    endcase
  end

  // reset fetch starts at the reset vector, only known pc source
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_q <= '0;
      r_q.st <= circ_pkg::CIRC_VEC_LO;
      r_q.vec <= RST_VEC;
      r_q.src <= circ_pkg::SRC_RST;
      r_q.pc <= circ_pkg::PC_RST;
      r_q.sp <= circ_pkg::SP_RST;
      r_q.mask <= 1'b1;
      r_q.nmi_prev <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign pc = r_q.pc;
  assign sp = r_q.sp;
  assign mask_flag = r_q.mask;
  assign svc_busy = (r_q.st != circ_pkg::CIRC_RUN);
  assign svc_src = r_q.src;
  assign bus_wr = r_q.wr;
  assign bus_rd = r_q.rd;
  assign bus_addr = r_q.addr;
  assign bus_wdata = r_q.wdata;
  assign pc_load = r_q.load;
  assign lnk.ack_irq = r_q.ack_irq;
  assign lnk.ack_nmi = r_q.ack_nmi;
endmodule

/* verilog/circ_per.sv */
// peripheral interface end: edge latch and open-drain request
// assumes the processor clears the latch when servicing a non-maskable request
`timescale 1ns/1ps
module circ_per #(
  parameter bit USE_NMI = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  circ_if.per lnk,
  input wire logic dev_in,
  input wire logic int_en,
  input wire logic en_wr,
  input wire logic clr,
  output logic flag
);
  typedef struct packed {
    logic prev;
    logic latch;
    logic en;
  } circ_per_t;
  circ_per_t r_q, r_d;
  logic in_s;
  logic ack;

  circ_sync u_in (
    .core_clk(core_clk),
    .rst(rst),
    .d(dev_in),
    .q(in_s)
  );

  assign ack = USE_NMI ? lnk.ack_nmi : lnk.ack_irq;

  // edge set wins over a clear in the same cycle
  always_comb begin
    r_d = r_q;
    r_d.prev = in_s;
    if (en_wr) begin
      r_d.en = int_en;
    end
    if (clr || ack) begin
      r_d.latch = 1'b0;
    end
    if (r_q.prev != in_s) begin
      r_d.latch = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_q <= '0;
      r_q.prev <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // latch set with enable high drives the shared line low
  assign lnk.irq_oe_n = USE_NMI ? 1'b1 : !(r_q.latch && r_q.en);
  assign lnk.nmi_oe_n = USE_NMI ? !(r_q.latch && r_q.en) : 1'b1;
  assign flag = r_q.latch;
endmodule

/* verilog/circ_sync.sv */
// two-flop synchroniser for a line from outside the clock
// assumes idle level is high (released request lines read high)
`timescale 1ns/1ps
module circ_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } circ_sync_t;
  circ_sync_t r_q, r_d;

  // first stage is read only by the second
  always_comb begin
    r_d = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_q <= '1;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;
endmodule
